// >>> rtl/slock_pkg.sv
package slock_pkg;

    localparam int ADDR_W    = 7;
    localparam int DATA_W    = 8;
    localparam int COUNT_W   = 6;
    localparam int LOCK_BITS = 7;
    localparam int SCRATCH_N = 4;
    localparam int WR_SLOTS  = 3;

    // register offsets
    localparam logic [6:0] ADDR_SCRATCH_FIRST = 7'h06;
    localparam logic [6:0] ADDR_SCRATCH_LAST  = 7'h09;
    localparam logic [6:0] ADDR_LOCK          = 7'h0a;
    localparam logic [6:0] ADDR_IDENTITY      = 7'h7e;

    // protected areas, index = lock bit
    localparam logic [6:0][6:0] LOCK_LO = {
        7'h68, 7'h50, 7'h40, 7'h30, 7'h20, 7'h10, 7'h06
    };
    localparam logic [6:0][6:0] LOCK_HI = {
        7'h6f, 7'h5f, 7'h4f, 7'h3f, 7'h2f, 7'h1f, 7'h09
    };

    // field positions
    localparam int RO_FLAG_BIT   = 0;
    localparam int LOCK_RSVD_BIT = 7;

    // reset values
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [6:0] LOCK_RESET    = 7'h00;

    // frame lengths in bits
    localparam logic [5:0] FRAME_SHORT  = 6'h10;
    localparam logic [5:0] FRAME_MID    = 6'h18;
    localparam logic [5:0] FRAME_LONG   = 6'h20;
    localparam logic [5:0] BYTE_BITS    = 6'h08;
    localparam logic [5:0] ECHO_AFTER   = 6'h20;
    localparam logic [5:0] COUNT_MAX    = 6'h3f;

    typedef enum logic [1:0] {
        SLOCK_IDLE   = 2'b00,
        SLOCK_SHIFT  = 2'b01,
        SLOCK_COMMIT = 2'b10
    } slock_state_t;

endpackage

// >>> rtl/slock_sync.sv
`timescale 1ns/1ps

module slock_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_a;

    // two flops per bit; the first is read by the second only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_a  <= '0;
            sync_out <= '0;
        end else begin
            stage_a  <= async_in;
            sync_out <= stage_a;
        end
    end

endmodule // slock_sync

// >>> rtl/slock_spi_regs.sv
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] select low active; output floats when high
// [RULE_02] sample on falling, shift on rising edge
// [RULE_03] master idles clock low; pin pulled down
// [RULE_04] 8-bit registers with 7-bit addresses
// [RULE_05] first byte address plus read-only lsb
// [RULE_06] read-only flag set: no register changes
// [RULE_07] 24/32-bit frames auto-increment the address
// [RULE_08] addressed contents shifted out, full duplex
// [RULE_09] unimplemented or overflow writes silently dropped
// [RULE_10] bad write length aborts, sets failure flag
// [RULE_11] reads past 32 bits echo input
// [RULE_12] reserved bits writable, no effect
// [RULE_13] locks gate only serial writes
// [RULE_14] lock bits 0-2 guard 06-09,10-1f,20-2f
// [RULE_15] lock bits 3-6 guard 30-5f, 68-6f
// [RULE_16] lock one blocks writes; bit 7 reserved
// [RULE_17] four scratch bytes at 06h to 09h
// [RULE_18] read-only identity byte at 7eh
// [RULE_19] address space 00h to 7fh
// [RULE_20] bytes travel most significant bit first

module slock_spi_regs #(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a // arbitrary value
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       select_low_pin,
    input  wire logic       serial_clk_pin,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin,
    output logic            serial_out_oe,
    output logic            frame_length_failure_flag,
    input  wire logic       failure_clear,
    output logic [6:0]      lock_areas,
    output logic            ext_wr_valid,
    output logic [6:0]      ext_wr_addr,
    output logic [7:0]      ext_wr_data,
    output logic [6:0]      ext_rd_addr,
    input  wire logic [7:0] ext_rd_data
);

    logic                       rst_meta;
    logic                       rst_n;
    logic [2:0]                 pins_s;
    logic                       cs_active;
    logic                       sck_s;
    logic                       sdi_s;
    logic                       sck_prev;
    logic                       cs_prev;
    logic                       sck_fall;
    logic                       sck_rise;
    logic                       cs_start;
    logic                       cs_end;
    slock_pkg::slock_state_t    state;
    slock_pkg::slock_state_t    next_state;
    logic [5:0]                 bit_count;
    logic [7:0]                 shift_in;
    logic [7:0]                 next_byte;
    logic [6:0]                 frame_addr;
    logic                       read_only;
    logic [7:0]                 wr_bytes [slock_pkg::WR_SLOTS];
    logic [7:0]                 out_shift;
    logic                       length_ok;
    logic [1:0]                 commit_idx;
    logic [1:0]                 commit_last;
    logic [7:0]                 wr_sum;
    logic [7:0]                 rd_sum;
    logic [1:0]                 rd_idx;
    logic [7:0]                 rd_data;
    logic                       wr_allowed;
    logic [7:0]                 scratch [slock_pkg::SCRATCH_N];
    logic [6:0]                 lock_reg;
    logic                       echo_on;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    slock_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({~select_low_pin, serial_clk_pin, serial_in_pin}),
        .sync_out (pins_s)
    );

    assign cs_active = pins_s[2]; // see [RULE_01]
    assign sck_s     = pins_s[1];
    assign sdi_s     = pins_s[0];

    // edge finding on the sampled serial clock and select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev <= 1'b0; // see [RULE_03]
            cs_prev  <= 1'b0;
        end else begin
            sck_prev <= sck_s;
            cs_prev  <= cs_active;
        end
    end

    assign sck_fall = sck_prev & ~sck_s & cs_active; // see [RULE_02]
    assign sck_rise = ~sck_prev & sck_s & cs_active; // see [RULE_02]
    assign cs_start = cs_active & ~cs_prev;
    assign cs_end   = ~cs_active & cs_prev;

    function automatic logic area_locked(input logic [6:0] a,
                                         input logic [6:0] lk);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < slock_pkg::LOCK_BITS; i++) begin
            if (lk[i] && a >= slock_pkg::LOCK_LO[i] &&
                a <= slock_pkg::LOCK_HI[i]) begin
                hit = 1'b1; // see [RULE_14] see [RULE_15] see [RULE_16]
            end
        end
        return hit;
    endfunction

    assign length_ok = (bit_count == slock_pkg::FRAME_SHORT) ||
                       (bit_count == slock_pkg::FRAME_MID) ||
                       (bit_count == slock_pkg::FRAME_LONG); // see [RULE_10]

    // frame sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            slock_pkg::SLOCK_IDLE: begin
                if (cs_start) begin
                    next_state = slock_pkg::SLOCK_SHIFT;
                end
            end
            slock_pkg::SLOCK_SHIFT: begin
                if (cs_end) begin
                    if (!read_only && length_ok) begin // see [RULE_06]
                        next_state = slock_pkg::SLOCK_COMMIT;
                    end else begin
                        next_state = slock_pkg::SLOCK_IDLE;
                    end
                end
            end
            slock_pkg::SLOCK_COMMIT: begin
                if (commit_idx == commit_last) begin
                    next_state = slock_pkg::SLOCK_IDLE;
                end
            end
            default: begin
                next_state = slock_pkg::SLOCK_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= slock_pkg::SLOCK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // input shifting, msb first
    assign next_byte = {shift_in[6:0], sdi_s}; // see [RULE_20]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_count  <= '0;
            shift_in   <= '0;
            frame_addr <= '0;
            read_only  <= 1'b0;
            for (int k = 0; k < slock_pkg::WR_SLOTS; k++) begin
                wr_bytes[k] <= '0;
            end
        end else if (cs_start) begin
            bit_count <= '0;
            read_only <= 1'b0;
        end else if (state == slock_pkg::SLOCK_SHIFT && sck_fall) begin
            shift_in <= next_byte;
            if (bit_count != slock_pkg::COUNT_MAX) begin
                bit_count <= bit_count + 6'h01; // see [RULE_10]
            end
            if (bit_count == slock_pkg::BYTE_BITS - 6'h01) begin
                frame_addr <= next_byte[7:1]; // see [RULE_04] see [RULE_05]
                read_only  <= next_byte[slock_pkg::RO_FLAG_BIT];
            end else if (bit_count[2:0] == 3'h7 &&
                         bit_count < slock_pkg::FRAME_LONG) begin
                wr_bytes[bit_count[4:3] - 2'h1] <= next_byte; // see [RULE_07]
            end
        end
    end

    // read side: byte n of the frame shows register addr + n - 1
    assign rd_idx      = bit_count[4:3] - 2'h1;
    assign rd_sum      = {1'b0, frame_addr} + {6'h00, rd_idx}; // see [RULE_07]
    assign ext_rd_addr = rd_sum[6:0];

    always_comb begin
        rd_data = 8'h00;
        if (rd_sum[7]) begin
            rd_data = 8'h00; // see [RULE_19]
        end else if (rd_sum[6:0] >= slock_pkg::ADDR_SCRATCH_FIRST &&
                     rd_sum[6:0] <= slock_pkg::ADDR_SCRATCH_LAST) begin
            rd_data = scratch[2'(rd_sum[6:0] -
                                 slock_pkg::ADDR_SCRATCH_FIRST)];
        end else if (rd_sum[6:0] == slock_pkg::ADDR_LOCK) begin
            rd_data = {1'b0, lock_reg}; // see [RULE_16] see [RULE_12]
        end else if (rd_sum[6:0] == slock_pkg::ADDR_IDENTITY) begin
            rd_data = IDENTITY_VALUE; // see [RULE_18]
        end else begin
            rd_data = ext_rd_data;
        end
    end

    assign echo_on = read_only && bit_count >= slock_pkg::ECHO_AFTER;

    // output shifting, full duplex with the input
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_shift      <= '0;
            serial_out_pin <= 1'b0;
        end else if (cs_start) begin
            out_shift      <= '0;
            serial_out_pin <= 1'b0;
        end else if (state == slock_pkg::SLOCK_SHIFT) begin
            if (echo_on) begin
                serial_out_pin <= sdi_s; // see [RULE_11]
            end else if (sck_rise) begin
                if (bit_count[2:0] == 3'h0 &&
                    bit_count >= slock_pkg::BYTE_BITS &&
                    bit_count < slock_pkg::FRAME_LONG) begin
                    serial_out_pin <= rd_data[7]; // see [RULE_08]
                    out_shift      <= {rd_data[6:0], 1'b0};
                end else begin
                    serial_out_pin <= out_shift[7]; // see [RULE_20]
                    out_shift      <= {out_shift[6:0], 1'b0};
                end
            end
        end
    end

    assign serial_out_oe = cs_active; // see [RULE_01]

    // commit of a well-formed write after select release
    assign commit_last = bit_count[4:3] - 2'h2;
    assign wr_sum      = {1'b0, frame_addr} + {6'h00, commit_idx};
    assign wr_allowed  = (state == slock_pkg::SLOCK_COMMIT) && !wr_sum[7] &&
                         !area_locked(wr_sum[6:0], lock_reg); // see [RULE_13]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            commit_idx <= '0;
        end else if (state == slock_pkg::SLOCK_COMMIT) begin
            commit_idx <= commit_idx + 2'h1;
        end else begin
            commit_idx <= '0;
        end
    end

    generate
        for (genvar g = 0; g < slock_pkg::SCRATCH_N; g++) begin : g_scratch
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    scratch[g] <= slock_pkg::SCRATCH_RESET;
                end else if (wr_allowed && wr_sum[6:0] ==
                             slock_pkg::ADDR_SCRATCH_FIRST + 7'(g)) begin
                    scratch[g] <= wr_bytes[commit_idx]; // see [RULE_17]
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= slock_pkg::LOCK_RESET;
        end else if (wr_allowed && wr_sum[6:0] == slock_pkg::ADDR_LOCK) begin
            lock_reg <= wr_bytes[commit_idx][6:0]; // see [RULE_12]
        end
    end

    assign lock_areas = lock_reg;

    // writes to other addresses go out; unused ones are simply dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_wr_valid <= 1'b0;
            ext_wr_addr  <= '0;
            ext_wr_data  <= '0;
        end else begin
            ext_wr_valid <= wr_allowed && // see [RULE_09]
                !(wr_sum[6:0] >= slock_pkg::ADDR_SCRATCH_FIRST &&
                  wr_sum[6:0] <= slock_pkg::ADDR_LOCK) &&
                wr_sum[6:0] != slock_pkg::ADDR_IDENTITY; // see [RULE_18]
            ext_wr_addr  <= wr_sum[6:0];
            ext_wr_data  <= wr_bytes[commit_idx];
        end
    end

    // failure flag: set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_length_failure_flag <= 1'b0;
        end else if (state == slock_pkg::SLOCK_SHIFT && cs_end &&
                     !read_only && !length_ok) begin
            frame_length_failure_flag <= 1'b1; // see [RULE_10]
        end else if (failure_clear) begin
            frame_length_failure_flag <= 1'b0;
        end
    end

endmodule // slock_spi_regs

// >>> verification/slock_spi_regs_assertions.sv
`timescale 1ns/1ps
module slock_chk (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       select_low_pin,
    input wire logic       failure_clear,
    input wire logic       serial_out_oe,
    input wire logic       frame_length_failure_flag,
    input wire logic [6:0] lock_areas,
    input wire logic       ext_wr_valid,
    input wire logic [6:0] ext_wr_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    function automatic logic hit(logic [6:0] a, logic [6:0] lk);
        hit = 1'b0;
        for (int i = 0; i < 7; i++)
            if (lk[i] && a >= slock_pkg::LOCK_LO[i]
                && a <= slock_pkg::LOCK_HI[i])
                hit = 1'b1;
    endfunction
    sequence s_sel_high;
        select_low_pin [*4];
    endsequence
    sequence s_sel_low;
        !select_low_pin [*4];
    endsequence
    sequence s_burst;
        ext_wr_valid ##1 ext_wr_valid;
    endsequence
    a_oe_float: assert property (
        s_sel_high |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_oe_drive: assert property (
        s_sel_low |-> serial_out_oe)
        else $error("output not driven while selected");
    a_flag_clear: assert property (
        select_low_pin [*6] ##0 failure_clear |=> !frame_length_failure_flag)
        else $error("flag not cleared");
    a_flag_hold: assert property (
        frame_length_failure_flag && !failure_clear
        |=> frame_length_failure_flag) else $error("flag dropped");
    a_flag_cause: assert property (
        $rose(frame_length_failure_flag) |-> select_low_pin)
        else $error("flag set inside frame");
    a_wr_outside: assert property (
        ext_wr_valid |-> $past(select_low_pin, 3))
        else $error("write inside frame");
    a_wr_step: assert property (
        s_burst |-> ext_wr_addr == 7'($past(ext_wr_addr) + 7'h01))
        else $error("address not advanced by one");
    a_wr_local: assert property (
        ext_wr_valid |-> !(ext_wr_addr inside {[7'h06:7'h0a], 7'h7e}))
        else $error("local address written outside");
    a_wr_lock: assert property (
        ext_wr_valid |-> !hit(ext_wr_addr, lock_areas))
        else $error("locked write");
    a_lock_quiet: assert property (
        !$stable(lock_areas) |-> $past(select_low_pin, 3))
        else $error("lock changed in frame");
endmodule // slock_chk

bind slock_spi_regs slock_chk u_chk (.sys_clk, .reset_n, .select_low_pin,
    .failure_clear, .serial_out_oe, .frame_length_failure_flag,
    .lock_areas, .ext_wr_valid, .ext_wr_addr);

// >>> verification/slock_master.sv
`timescale 1ns/1ps
module slock_master (
    output logic      select_low_pin,
    output logic      serial_clk_pin,
    output logic      serial_in_pin,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_oe
);
    logic [39:0] rx_word;
    event        done;
    initial begin
        select_low_pin = 1'b1;
        serial_clk_pin = 1'b0;
        serial_in_pin  = 1'b0;
        rx_word        = '0;
    end
    task automatic xfer(input int n, input logic [39:0] tx);
        @(negedge tb_top.sys_clk);
        select_low_pin = 1'b0;
        rx_word = '0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            serial_clk_pin = 1'b1;
            serial_in_pin  = tx[i];
            #62.5;
            serial_clk_pin = 1'b0;
            rx_word = {rx_word[38:0], serial_out_oe ? serial_out_pin : 1'bx};
            #62.5;
        end
        #100;
        select_low_pin = 1'b1;
        serial_in_pin  = ~serial_in_pin;
        -> done;
        #100;
    endtask
endmodule // slock_master

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] ID = 8'h5a; // arbitrary value
    logic        sys_clk, reset_n, failure_clear, ext_wr_valid;
    logic        select_low_pin, serial_clk_pin, serial_in_pin;
    logic        serial_out_pin, serial_out_oe, frame_length_failure_flag;
    logic [6:0]  lock_areas, ext_wr_addr, ext_rd_addr;
    logic [7:0]  ext_wr_data, ext_rd_data, d [4];
    logic [39:0] eq [$], mq [$], wm;
    logic [14:0] wq [$];
    int          fail_count = 0, cmp_count = 0, seed = 18;
    function automatic logic [7:0] fx(logic [6:0] a);
        return {1'b1, a} ^ 8'h3c;
    endfunction
    assign ext_rd_data = fx(ext_rd_addr);
    slock_spi_regs #(.IDENTITY_VALUE(ID)) uut (.sys_clk, .reset_n,
        .select_low_pin, .serial_clk_pin, .serial_in_pin, .serial_out_pin,
        .serial_out_oe, .frame_length_failure_flag, .failure_clear,
        .lock_areas, .ext_wr_valid, .ext_wr_addr, .ext_wr_data,
        .ext_rd_addr, .ext_rd_data);
    slock_master mst (.select_low_pin, .serial_clk_pin, .serial_in_pin,
        .serial_out_pin, .serial_out_oe);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [39:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (eq.size() != 0 || wq.size() != 0)
            fail_count++;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic frame(input int n, input logic [6:0] a, input logic ro,
                         input logic [31:0] dat, input logic [39:0] e, m);
        eq.push_back(e >> (40 - n));
        mq.push_back(m >> (40 - n));
        mst.xfer(n, {a, ro, dat} >> (40 - n));
    endtask
    initial forever begin
        @(mst.done);
        wm = mq.pop_front();
        check(mst.rx_word & wm, eq.pop_front() & wm);
    end
    always @(negedge sys_clk) begin
        if (ext_wr_valid === 1'b1)
            check({ext_wr_addr, ext_wr_data},
                  wq.pop_front());
    end
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
    initial begin
        logic [6:0]  lk, a;
        logic [7:0]  dd, ee;
        logic [31:0] r;
        int          bad [4];
        reset_n = 1'b0;
        failure_clear = 1'b0;
        bad = '{12, 20, 31, 40};
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        check({frame_length_failure_flag, lock_areas, serial_out_oe},
              '0);
        foreach (d[i]) d[i] = 8'($random(seed));
        r = $random(seed);
        frame(32, 7'h06, 1'b0, {d[0], d[1], d[2], 8'h00}, '0,
              '1);
        frame(24, 7'h09, 1'b0, {d[3], 24'h0}, '0, '1);
        frame(32, 7'h07, 1'b1, r, {8'h00, d[1], d[2], d[3], 8'h0},
              '1);
        foreach (bad[k]) begin
            frame(bad[k], 7'h06, 1'b0, r, '0, '0);
            check(frame_length_failure_flag, 1'b1);
            @(negedge sys_clk) failure_clear = 1'b1;
            @(negedge sys_clk) failure_clear = 1'b0;
            check(frame_length_failure_flag, 1'b0);
        end
        frame(20, 7'h06, 1'b1, r, '0, '0);
        check(frame_length_failure_flag, 1'b0);
        for (int i = 0; i < 7; i++) begin
            lk = 7'h01 << i;
            dd = 8'($random(seed));
            ee = 8'($random(seed));
            frame(16, 7'h0a, 1'b0, {1'b1, lk, 24'h0}, '0, '0);
            frame(16, 7'h0a, 1'b1, r, {9'h0, lk, 24'h0},
                  {16'hff7f, 24'h0});
            check(lock_areas, lk);
            a = slock_pkg::LOCK_HI[i] - 7'h01;
            frame(24, a, 1'b0, {dd, ee, 16'h0}, '0, '0);
            a = slock_pkg::LOCK_LO[i] - 7'h02;
            wq.push_back({a, dd});
            wq.push_back({a + 7'h01, ee});
            frame(24, a, 1'b0, {dd, ee, 16'h0}, '0, '0);
        end
        frame(16, 7'h0a, 1'b0, 32'h0, '0, '0);
        frame(32, 7'h07, 1'b1, r, {8'h00, d[1], d[2], d[3], 8'h0},
              '1);
        wq.push_back({7'h7f, ee});
        frame(32, 7'h7e, 1'b0, {dd, ee, 16'h0},
              {8'h00, ID, fx(7'h7f), 16'h0},
              {32'hffffffff, 8'h0});
        check(frame_length_failure_flag, 1'b0);
        frame(16, 7'h7e, 1'b1, r, {8'h00, ID, 24'h0}, '1);
        r = $random(seed);
        frame(40, 7'h06, 1'b1, r, {8'h00, d[0], d[1], d[2], r[7:0]},
              '1);
        repeat (20) @(negedge sys_clk);
        give_verdict();
    end
endmodule // tb_top
